/* ccdts_pkg.sv */
// ccdts_pkg.sv: shared constants, field layouts and types for the
// timing sequencer block.
// assumes one clock domain (core_clk) and a synchronous active-high reset.

package ccdts_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125; // core clock rate
	localparam int STEP_NS = 10; // nominal instruction step
	localparam int STEP_CYC = (STEP_NS * CLK_MHZ) / 1000 < 1 ? 1 :
		(STEP_NS * CLK_MHZ) / 1000; // one instruction per core cycle

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int PC_W = 8; // program address width
	localparam int PROG_DEPTH = 256; // instruction words
	localparam int STACK_DEPTH = 16; // nested call levels
	localparam int SP_W = 5; // stack pointer, 0..16
	localparam int CH_N = 8; // clock driver channels
	localparam int DAC_W = 14; // converter code width
	localparam int GP_N = 8; // general-purpose lines
	localparam int ADC_N = 4; // video channels
	localparam int ADC_W = 16; // sample width
	localparam int PAR_N = 16; // user parameters
	localparam int PAR_W = 16; // parameter width
	localparam int ACC_W = 28; // cds accumulator width
	localparam int INSTR_W = 160; // stored instruction width

	// ------------------------------------------------------------
	// register map (word offsets as byte addresses; program lanes at consecutive addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL = 12'h000; // enables, modes
	localparam logic [11:0] REG_STATUS = 12'h004; // pc, sp, flags
	localparam logic [11:0] REG_GPDIR = 12'h008; // pair directions
	localparam logic [11:0] REG_GPSRC = 12'h00C; // 2 bits per line
	localparam logic [11:0] REG_PIXEL = 12'h010; // last pixel, ch sel
	localparam logic [11:0] REG_PARAM = 12'h100; // staged params
	localparam logic [11:0] REG_SLEW = 12'h200; // fast 15:0 slow 31:16
	localparam logic [11:0] REG_PROG = 12'h800; // 5 words / instr

	// ------------------------------------------------------------
	// control field positions and reset values
	// ------------------------------------------------------------
	localparam int CTRL_RUN = 0; // sequencer runs
	localparam int CTRL_TRIGRST = 1; // trigger restarts program
	localparam int CTRL_HDR = 2; // 32-bit pixel mode
	localparam int CTRL_SWLOAD = 3; // software param load pulse
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] GSRC_LOW = 2'h0; // line source: constant low
	localparam logic [1:0] GSRC_HIGH = 2'h1; // constant high
	localparam logic [1:0] GSRC_SEQ = 2'h2; // sequencer bit
	localparam logic [15:0] SLEW_RST = 16'h0001;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {OP_NOP, OP_JUMP, OP_CALL, OP_RET} ccdts_op_e;

	// ------------------------------------------------------------
	// stored instruction layout, msb first
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0] pad; // unused, fills the word to 160 bits
		ccdts_op_e op; // operation
		logic cond; // execute only when condition holds
		logic [3:0] parIdx; // parameter tested
		logic [PC_W-1:0] target; // jump or call address
		logic [CH_N-1:0][DAC_W-1:0] level; // driver targets
		logic [CH_N-1:0] fastSel; // fast slew per channel
		logic clamp; // video dc-restore clamp
		logic sampRst; // reset-level sample window
		logic sampVid; // video-level sample window
		logic pixEnd; // close pixel, emit result
		logic [GP_N-1:0] gpBit; // sequencer line bits
		logic trigOut; // trigger out level
		logic [6:0] spare; // unused
	} ccdts_instr_s;

	// ------------------------------------------------------------
	// state carried to pins each step
	// ------------------------------------------------------------
	typedef struct packed {
		logic [CH_N-1:0][DAC_W-1:0] dac; // slewed converter codes
		logic clamp;
		logic sampRst;
		logic sampVid;
		logic trigOut;
	} ccdts_out_s;

	// parameter condition: a nonzero value lets the instruction act
	function automatic logic ccdts_cond(input logic [PAR_W-1:0] v);
		return v != '0;
	endfunction

endpackage

/* ccdts_prog_ram.sv */
// ccdts_prog_ram.sv: instruction memory, one write port, one
// registered read port.
// assumes writes and reads share core_clk.

`timescale 1ns/1ps

module ccdts_prog_ram
	import ccdts_pkg::*;
(
	input wire logic core_clk,
	input wire logic we,
	input wire logic [PC_W-1:0] waddr,
	input wire logic [2:0] wword,
	input wire logic [31:0] wdata,
	input wire logic [PC_W-1:0] raddr,
	output logic [INSTR_W-1:0] rdata
);

	// five 32-bit lanes make one instruction word
	logic [31:0] mem [0:PROG_DEPTH-1][0:4];

	// write one lane, read whole word registered
	always_ff @(posedge core_clk)
	begin
		if (we && wword < 3'd5)
		begin
			mem[waddr][wword] <= wdata;
		end
		rdata <= {mem[raddr][4], mem[raddr][3], mem[raddr][2],
			mem[raddr][1], mem[raddr][0]};
	end

endmodule // ccdts_prog_ram

/* ccdts_sequencer.sv */
// ccdts_sequencer.sv: single-cycle timing microsequencer with call
// stack, slew-controlled driver codes, line drive and digital cds.
// assumes the master clock and the backplane reset/load lines are
// synchronous to core_clk; software uses an avalon-mm master.
//
// Functional notes
// - all state runs on shared master clock
// - ops are nop, jump, call, return only
// - one instruction completes each clock cycle
// - execution conditional on user parameter value
// - return stack holds sixteen nested calls
// - instruction carries levels, strobes, trigger outputs
// - eight channels of fourteen-bit codes
// - new target level every clock tick
// - outputs slew toward target, fast or slow
// - per-channel rates; select updated each tick
// - general lines directed in pairs
// - output line: high, low or sequencer
// - program strobes clamp periodically, once per line
// - four sixteen-bit video channels in
// - average reset and video samples, difference
// - sixteen-bit pixels, thirty-two in hdr mode
// - enabled trigger restarts the timing program
// - staged parameters apply on load strobe
//
// Added by the designer: the register addresses and the Avalon-MM slave port.

`timescale 1ns/1ps

module ccdts_sequencer
	import ccdts_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic sync_sequencer_reset,
	input wire logic param_load_strobe,
	input wire logic [ADC_N-1:0][ADC_W-1:0] adcData,
	output ccdts_out_s drv,
	input wire logic [GP_N-1:0] gpIn,
	output logic [GP_N-1:0] gpOut,
	output logic [GP_N-1:0] gpOe,
	output logic [31:0] pixData,
	output logic [ADC_N-1:0] pixValid
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0] ctrl, next_ctrl; // control word
	logic [3:0] gpDir, next_gpDir; // one bit per pair, 1 = out
	logic [15:0] gpSrc, next_gpSrc; // 2 bits per line
	logic [1:0] pixSel, next_pixSel; // channel shown in readback
	logic [PAR_W-1:0] parStage [PAR_N]; // written by software
	logic [PAR_W-1:0] next_parStage [PAR_N];
	logic [PAR_W-1:0] parLive [PAR_N]; // used by the program
	logic [PAR_W-1:0] next_parLive [PAR_N];
	logic [15:0] slewFast [CH_N], next_slewFast [CH_N];
	logic [15:0] slewSlow [CH_N], next_slewSlow [CH_N];
	logic [31:0] rdReg, next_rdReg; // read data flop
	logic rdPend, next_rdPend; // read answered next cycle
	logic [31:0] pixHold [ADC_N], next_pixHold [ADC_N];

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	// writes complete at once; reads take one wait cycle so data
	// can come from a flop
	logic wrHit;
	logic ramWe;
	logic [31:0] beMask;

	assign avs_waitrequest = avs_read && !rdPend;
	assign avs_readdata = rdReg;
	assign wrHit = avs_write;
	assign ramWe = wrHit && avs_address[11];
	assign beMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// byte-lane merge used for register writes except pixel select and slew
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [31:0] m);
		return (old & ~m) | (wd & m);
	endfunction

	// ------------------------------------------------------------
	// sequencer core signals
	// ------------------------------------------------------------
	logic [PC_W-1:0] pc, next_pc; // program counter
	logic [SP_W-1:0] sp, next_sp; // stack depth
	logic [PC_W-1:0] stack [STACK_DEPTH]; // return addresses
	logic [PC_W-1:0] next_stack [STACK_DEPTH];
	logic stackErr, next_stackErr; // over/underflow seen
	logic [INSTR_W-1:0] ramData; // fetched word
	ccdts_instr_s ins; // current instruction
	logic restart; // program restart this cycle
	logic running;
	logic primed, next_primed; // fetch pipeline filled
	logic [PC_W-1:0] fetchAddr; // address presented to memory

	assign ins = ccdts_instr_s'(ramData);
	assign running = ctrl[CTRL_RUN] && primed;
	// trigger may stand in for the backplane reset
	assign restart = sync_sequencer_reset
		|| (ctrl[CTRL_TRIGRST] && gpIn[0])
		|| !ctrl[CTRL_RUN];

	ccdts_prog_ram u_ram (
		.core_clk(core_clk),
		.we(ramWe),
		.waddr(avs_address[10:3]),
		.wword(avs_address[2:0]), // lane index, lane 0 holds the lsbs
		.wdata(avs_writedata),
		.raddr(fetchAddr),
		.rdata(ramData)
	);

	// ------------------------------------------------------------
	// register next-state
	// ------------------------------------------------------------
	always_comb
	begin
		next_ctrl = ctrl;
		next_ctrl[CTRL_SWLOAD] = 1'b0; // self-clearing pulse
		next_gpDir = gpDir;
		next_gpSrc = gpSrc;
		next_pixSel = pixSel;
		next_rdPend = avs_read && !rdPend;
		next_rdReg = rdReg;
		next_parStage = parStage;
		next_parLive = parLive;
		next_slewFast = slewFast;
		next_slewSlow = slewSlow;
		// staged parameters go live together on the strobe
		if (param_load_strobe || ctrl[CTRL_SWLOAD])
		begin
			next_parLive = parStage;
		end
		if (wrHit && !avs_address[11])
		begin
			if (avs_address == REG_CTRL)
			begin
				next_ctrl = merge(ctrl, avs_writedata, beMask);
			end
			else if (avs_address == REG_GPDIR)
			begin
				next_gpDir = 4'(merge(32'(gpDir), avs_writedata, beMask));
			end
			else if (avs_address == REG_GPSRC)
			begin
				next_gpSrc = 16'(merge(32'(gpSrc), avs_writedata, beMask));
			end
			else if (avs_address == REG_PIXEL)
			begin
				next_pixSel = avs_writedata[1:0];
			end
			else if (avs_address[11:8] == REG_PARAM[11:8]
				&& avs_address[7:6] == 2'b00)
			begin
				next_parStage[avs_address[5:2]] = 16'(merge(
					32'(parStage[avs_address[5:2]]), avs_writedata, beMask));
			end
			else if (avs_address[11:8] == REG_SLEW[11:8]
				&& avs_address[7:5] == 3'b000)
			begin
				next_slewFast[avs_address[4:2]] = avs_writedata[15:0];
				next_slewSlow[avs_address[4:2]] = avs_writedata[31:16];
			end
		end
		// read decode, unmapped reads zero
		if (avs_read && !rdPend)
		begin
			if (avs_address == REG_CTRL)
				next_rdReg = ctrl;
			else if (avs_address == REG_STATUS)
				next_rdReg = {16'h0000, 2'b00, stackErr, sp, pc};
			else if (avs_address == REG_GPDIR)
				next_rdReg = {20'h0_0000, gpIn, gpDir};
			else if (avs_address == REG_GPSRC)
				next_rdReg = {16'h0000, gpSrc};
			else if (avs_address == REG_PIXEL)
				next_rdReg = pixHold[pixSel];
			else if (avs_address[11:8] == REG_PARAM[11:8]
				&& avs_address[7:6] == 2'b00)
				next_rdReg = {parLive[avs_address[5:2]],
					parStage[avs_address[5:2]]};
			else if (avs_address[11:8] == REG_SLEW[11:8]
				&& avs_address[7:5] == 3'b000)
				next_rdReg = {slewSlow[avs_address[4:2]],
					slewFast[avs_address[4:2]]};
			else
				next_rdReg = 32'h0000_0000;
		end
	end

	// register flops, synchronous reset
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl <= CTRL_RST;
			gpDir <= '0;
			gpSrc <= '0;
			pixSel <= '0;
			rdReg <= '0;
			rdPend <= 1'b0;
			for (int i = 0; i < PAR_N; i++)
			begin
				parStage[i] <= '0;
				parLive[i] <= '0;
			end
			for (int i = 0; i < CH_N; i++)
			begin
				slewFast[i] <= SLEW_RST;
				slewSlow[i] <= SLEW_RST;
			end
		end
		else
		begin
			ctrl <= next_ctrl;
			gpDir <= next_gpDir;
			gpSrc <= next_gpSrc;
			pixSel <= next_pixSel;
			rdReg <= next_rdReg;
			rdPend <= next_rdPend;
			parStage <= next_parStage;
			parLive <= next_parLive;
			slewFast <= next_slewFast;
			slewSlow <= next_slewSlow;
		end
	end

	// ------------------------------------------------------------
	// program flow
	// ------------------------------------------------------------
	// the memory read address is the next pc, so the fetched word
	// matches pc on every edge: one instruction per clock
	assign fetchAddr = next_pc;

	always_comb
	begin
		next_pc = pc + 1'b1;
		next_sp = sp;
		next_stack = stack;
		next_stackErr = stackErr;
		next_primed = 1'b1;
		if (restart)
		begin
			next_pc = '0;
			next_sp = '0;
			next_primed = 1'b0;
		end
		else if (!running)
		begin
			next_pc = '0;
		end
		else if (!ins.cond || ccdts_cond(parLive[ins.parIdx]))
		begin
			case (ins.op)
				OP_NOP:
					next_pc = pc + 1'b1;
				OP_JUMP:
					next_pc = ins.target;
				OP_CALL:
				begin
					// full stack: flag and fall through
					if (sp < SP_W'(STACK_DEPTH))
					begin
						next_stack[sp[3:0]] = pc + 1'b1;
						next_sp = sp + 1'b1;
						next_pc = ins.target;
					end
					else
						next_stackErr = 1'b1;
				end
				OP_RET:
				begin
					if (sp != '0)
					begin
						next_sp = sp - 1'b1;
						next_pc = stack[4'(sp - 1'b1)];
					end
					else
						next_stackErr = 1'b1;
				end
				default:
					next_pc = pc + 1'b1;
			endcase
		end
	end

	// flow flops, all on the master clock
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pc <= '0;
			sp <= '0;
			stackErr <= 1'b0;
			primed <= 1'b0;
			for (int i = 0; i < STACK_DEPTH; i++)
				stack[i] <= '0;
		end
		else
		begin
			pc <= next_pc;
			sp <= next_sp;
			stackErr <= next_stackErr;
			primed <= next_primed;
			stack <= next_stack;
		end
	end

	// ------------------------------------------------------------
	// driver slew and strobes
	// ------------------------------------------------------------
	ccdts_out_s next_drv;

	// step one code toward its target by up to rate, never overshooting
	function automatic logic [DAC_W-1:0] slew(input logic [DAC_W-1:0] cur,
		input logic [DAC_W-1:0] tgt, input logic [15:0] rate);
		logic [DAC_W:0] d;
		d = '0;
		if (tgt > cur)
		begin
			d = {1'b0, tgt} - {1'b0, cur};
			return (d > 15'(rate)) ? cur + DAC_W'(rate) : tgt;
		end
		d = {1'b0, cur} - {1'b0, tgt};
		return (d > 15'(rate)) ? cur - DAC_W'(rate) : tgt;
	endfunction

	always_comb
	begin
		next_drv = drv;
		for (int c = 0; c < CH_N; c++)
		begin
			// fresh target and rate choice every tick
			next_drv.dac[c] = slew(drv.dac[c], ins.level[c],
				ins.fastSel[c] ? slewFast[c] : slewSlow[c]);
		end
		next_drv.clamp = running && ins.clamp;
		next_drv.sampRst = running && ins.sampRst;
		next_drv.sampVid = running && ins.sampVid;
		next_drv.trigOut = running && ins.trigOut;
		if (!running)
			next_drv.dac = drv.dac; // hold levels while stopped
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			drv <= '0;
		else
			drv <= next_drv;
	end

	// ------------------------------------------------------------
	// general-purpose lines
	// ------------------------------------------------------------
	logic [GP_N-1:0] next_gpOut, next_gpOe;

	always_comb
	begin
		for (int g = 0; g < GP_N; g++)
		begin
			next_gpOe[g] = gpDir[g/2];
			case (gpSrc[2*g +: 2])
				GSRC_HIGH: next_gpOut[g] = 1'b1;
				GSRC_SEQ: next_gpOut[g] = running && ins.gpBit[g];
				default: next_gpOut[g] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			gpOut <= '0;
			gpOe <= '0;
		end
		else
		begin
			gpOut <= next_gpOut;
			gpOe <= next_gpOe;
		end
	end

	// ------------------------------------------------------------
	// digital cds
	// ------------------------------------------------------------
	// sums per channel, counts shared; averaging divides by count on
	// pixel end. two dividers per channel cost area but keep any
	// sample count legal.
	logic [ACC_W-1:0] sumR [ADC_N], sumV [ADC_N];
	logic [ACC_W-1:0] next_sumR [ADC_N], next_sumV [ADC_N];
	logic [11:0] cntR, cntV, next_cntR, next_cntV; // shared counts
	logic [31:0] next_pixData;
	logic [ADC_N-1:0] next_pixValid;

	always_comb
	begin
		next_sumR = sumR;
		next_sumV = sumV;
		next_cntR = cntR;
		next_cntV = cntV;
		next_pixHold = pixHold;
		next_pixData = pixData;
		next_pixValid = '0;
		for (int a = 0; a < ADC_N; a++)
		begin
			logic [31:0] avR, avV, dif;
			avR = 32'(sumR[a]) / (cntR == 0 ? 32'd1 : 32'(cntR));
			avV = 32'(sumV[a]) / (cntV == 0 ? 32'd1 : 32'(cntV));
			dif = avR - avV;
			if (drv.sampRst)
				next_sumR[a] = sumR[a] + ACC_W'(adcData[a]);
			if (drv.sampVid)
				next_sumV[a] = sumV[a] + ACC_W'(adcData[a]);
			if (running && ins.pixEnd)
			begin
				// hdr keeps 32 bits, else truncate to the low 16
				next_pixHold[a] = ctrl[CTRL_HDR] ? dif :
					{16'h0000, dif[15:0]};
				next_pixValid[a] = 1'b1;
				next_sumR[a] = '0;
				next_sumV[a] = '0;
			end
		end
		if (drv.sampRst)
			next_cntR = cntR + 1'b1;
		if (drv.sampVid)
			next_cntV = cntV + 1'b1;
		if (running && ins.pixEnd)
		begin
			next_cntR = '0;
			next_cntV = '0;
			next_pixData = next_pixHold[pixSel];
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cntR <= '0;
			cntV <= '0;
			pixData <= '0;
			pixValid <= '0;
			for (int a = 0; a < ADC_N; a++)
			begin
				sumR[a] <= '0;
				sumV[a] <= '0;
				pixHold[a] <= '0;
			end
		end
		else
		begin
			cntR <= next_cntR;
			cntV <= next_cntV;
			pixData <= next_pixData;
			pixValid <= next_pixValid;
			sumR <= next_sumR;
			sumV <= next_sumV;
			pixHold <= next_pixHold;
		end
	end

endmodule // ccdts_sequencer

/* ccdts_sequencer_chk.sv */
// ccdts_sequencer_chk.sv: port-level checks on the sequencer.
// assumes one core_clk domain with synchronous rst; bound by testbench.
`timescale 1ns/1ps
module ccdts_sequencer_chk
	import ccdts_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	input wire logic sync_sequencer_reset,
	input wire ccdts_out_s drv,
	input wire logic [GP_N-1:0] gpOe,
	input wire logic [ADC_N-1:0] pixValid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ----------------
	// bus timing
	// ----------------
	a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
	a_read_stall: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("read answered without stall");
	a_read_answer: assert property (avs_read && avs_waitrequest
		|=> !avs_waitrequest || !avs_read) else $error("read late");
	a_idle_nowait: assert property (!avs_read |-> !avs_waitrequest)
		else $error("stall without read");
	a_data_stands: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	// ----------------
	// sequencer and lines
	// ----------------
	// reset must win, so this one is not disabled by it
	a_rst_quiet: assert property (@(posedge core_clk) disable iff (1'b0)
		rst |=> drv == '0 && gpOe == '0 && pixValid == '0)
		else $error("outputs live in reset");
	a_pair_dir: assert property (gpOe[0] == gpOe[1] && gpOe[2] == gpOe[3]
		&& gpOe[4] == gpOe[5] && gpOe[6] == gpOe[7])
		else $error("line pair split");
	// pc held at the first instruction: its strobes stop moving
	a_seq_restart: assert property (sync_sequencer_reset[*6] |->
		$stable(drv.trigOut) && $stable(drv.clamp))
		else $error("program runs in reset");
endmodule // ccdts_sequencer_chk

/* ccdts_far_end.sv */
// ccdts_far_end.sv: far side of the sequencer: adcs, lines, trigger.
// assumes drv is registered on core_clk; bench commands trigFire.
`timescale 1ns/1ps
module ccdts_far_end
	import ccdts_pkg::*;
(
	input wire logic core_clk,
	input wire ccdts_out_s drv,
	input wire logic [GP_N-1:0] gpOut,
	input wire logic [GP_N-1:0] gpOe,
	input wire logic trigFire,
	output logic [GP_N-1:0] gpIn,
	output logic [ADC_N-1:0][ADC_W-1:0] adcData
);
	localparam logic [GP_N-1:0] EXT_LEVEL = 8'hA4; // far-side line drivers
	// wire level: our driver only where the block has released the line
	always_comb
	begin
		for (int i = 0; i < GP_N; i++)
			gpIn[i] = gpOe[i] ? gpOut[i] : EXT_LEVEL[i];
		if (!gpOe[0])
			gpIn[0] = trigFire; // line 0 carries the trigger
	end
	// reset level above video level, one offset per channel
	always_comb
	begin
		for (int c = 0; c < ADC_N; c++)
			adcData[c] = drv.sampVid ? 16'(16'h1000 + c) : 16'(16'h3000 + c);
	end
endmodule // ccdts_far_end

/* testbench.sv */
// testbench.sv: directed avalon tests of the timing sequencer.
// assumes package, design, far-end model and checker compiled first.
`timescale 1ns/1ps
module testbench;
	import ccdts_pkg::*;
	logic core_clk = 0;
	logic rst = 1;
	logic [11:0] avs_address = '0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = '0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sync_sequencer_reset = 0;
	logic param_load_strobe = 0;
	logic trigFire = 0;
	logic [ADC_N-1:0][ADC_W-1:0] adcData;
	ccdts_out_s drv;
	logic [GP_N-1:0] gpIn, gpOut, gpOe;
	logic [31:0] pixData;
	logic [ADC_N-1:0] pixValid;
	int n_errors = 0;
	int check_count = 0;
	logic [31:0] rd;
	logic t0;
	ccdts_instr_s ins;
	always #4 core_clk = ~core_clk;
	ccdts_sequencer dut (.core_clk, .rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .sync_sequencer_reset, .param_load_strobe,
		.adcData, .drv, .gpIn, .gpOut, .gpOe, .pixData, .pixValid);
	ccdts_far_end far (.core_clk, .drv, .gpOut, .gpOe, .trigFire,
		.gpIn, .adcData);
	// ----------------
	// helpers
	// ----------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] a);
		@(posedge core_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
	endtask
	// five words per instruction, lowest word first
	task automatic put(input int i, input ccdts_instr_s v);
		for (int w = 0; w < 5; w++)
			wr(12'h800 + 12'(i * 8 + w), v[w*32 +: 32]);
	endtask
	function automatic ccdts_instr_s mk(input ccdts_op_e op,
		input logic [7:0] tgt, input logic c, input logic t);
		ccdts_instr_s v;
		v = '0;
		v.op = op;
		v.target = tgt;
		v.cond = c;
		v.trigOut = t;
		v.gpBit = 8'hFF;
		return v;
	endfunction
	// idle loop at 1..2 with an empty stack
	task automatic loopchk(input string nm);
		rdr(REG_STATUS);
		chk(nm, 32'h0, 32'(rd[12:8]));
		chk(nm, 32'h1, 32'(rd[7:0] == 8'h01 || rd[7:0] == 8'h02));
	endtask
	task automatic pulse_load();
		@(posedge core_clk);
		param_load_strobe <= 1'b1;
		@(posedge core_clk);
		param_load_strobe <= 1'b0;
	endtask
	// watchdog: tests take a few hundred cycles
	initial
	begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		final_report();
	end
	// ----------------
	// tests
	// ----------------
	initial
	begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rdr(REG_CTRL);
		chk("ctrl", CTRL_RST, rd);
		rdr(REG_STATUS);
		chk("status", 32'h0, rd);
		rdr(REG_SLEW);
		chk("slew", {SLEW_RST, SLEW_RST}, rd);
		rdr(12'h040);
		chk("unmapped", 32'h0, rd);
		$display("test reset done");
		put(0, mk(OP_CALL, 8'h0A, 1'b0, 1'b0));
		put(10, mk(OP_CALL, 8'h14, 1'b0, 1'b0));
		put(20, mk(OP_RET, 8'h00, 1'b0, 1'b0));
		put(11, mk(OP_RET, 8'h00, 1'b0, 1'b0));
		put(1, mk(OP_JUMP, 8'h03, 1'b1, 1'b0));
		put(2, mk(OP_JUMP, 8'h01, 1'b0, 1'b1));
		put(3, mk(OP_CALL, 8'h03, 1'b0, 1'b0));
		ins = mk(OP_JUMP, 8'h04, 1'b0, 1'b0);
		ins.level[0] = 14'h0200;
		ins.level[1] = 14'h0200;
		ins.fastSel = 8'h01;
		put(4, ins);
		wr(REG_SLEW, 32'h0001_0010);
		wr(REG_CTRL, 32'h0000_0001);
		repeat (50) @(posedge core_clk);
		loopchk("nested return");
		@(negedge core_clk);
		t0 = drv.trigOut;
		@(negedge core_clk);
		chk("step", 32'(!t0), 32'(drv.trigOut));
		$display("test call done");
		wr(REG_PARAM, 32'h0000_0001);
		rdr(REG_PARAM);
		chk("staged", 32'h0000_0001, rd);
		loopchk("cond off");
		pulse_load();
		rdr(REG_PARAM);
		chk("live", 32'h0001_0001, rd);
		repeat (60) @(posedge core_clk);
		rdr(REG_STATUS);
		chk("deep", 32'h0000_3004, rd);
		chk("fast", 32'h0000_0200, 32'(drv.dac[0]));
		chk("slow", 32'h1, 32'(drv.dac[1] < 14'h0200));
		$display("test stack done");
		wr(REG_PARAM, 32'h0000_0000);
		pulse_load();
		repeat (10) @(posedge core_clk);
		rdr(REG_STATUS);
		chk("held", 32'h0000_3004, rd);
		wr(REG_CTRL, 32'h0000_0003);
		@(posedge core_clk);
		trigFire <= 1'b1;
		repeat (2) @(posedge core_clk);
		trigFire <= 1'b0;
		repeat (50) @(posedge core_clk);
		loopchk("trigger");
		@(posedge core_clk);
		sync_sequencer_reset <= 1'b1;
		repeat (8) @(posedge core_clk);
		rdr(REG_STATUS);
		chk("sync", 32'h0, 32'(rd[12:0]));
		sync_sequencer_reset <= 1'b0;
		repeat (50) @(posedge core_clk);
		loopchk("restart");
		$display("test restart done");
		// line 0 is driven below, so it must stop restarting the program
		wr(REG_CTRL, 32'h0000_0001);
		wr(REG_GPDIR, 32'h0000_0005);
		wr(REG_GPSRC, 32'h0000_0601);
		repeat (5) @(posedge core_clk);
		chk("gpOe", 32'h33, 32'(gpOe));
		chk("gpOut", 32'h31, 32'(gpOut & gpOe));
		rdr(REG_GPDIR);
		chk("gpdir", 32'h0000_0B55, rd);
		$display("test lines done");
		// two reset samples, one video sample, a gap, then close
		ins = mk(OP_NOP, 8'h00, 1'b0, 1'b0);
		ins.sampRst = 1'b1;
		ins.clamp = 1'b1;
		put(5, ins);
		ins.clamp = 1'b0;
		put(6, ins);
		ins.sampRst = 1'b0;
		ins.sampVid = 1'b1;
		put(7, ins);
		put(8, mk(OP_NOP, 8'h00, 1'b0, 1'b0));
		ins = mk(OP_JUMP, 8'h05, 1'b0, 1'b0);
		ins.pixEnd = 1'b1;
		put(9, ins);
		put(2, mk(OP_JUMP, 8'h05, 1'b0, 1'b0));
		do @(posedge core_clk); while (pixValid !== 4'hF);
		chk("pixel", 32'h0000_2000, pixData);
		rdr(REG_PIXEL);
		chk("pixsel", 32'h0000_2000, rd);
		$display("test cds done");
		final_report();
	end
endmodule // testbench
bind ccdts_sequencer ccdts_sequencer_chk chk_i (.core_clk, .rst, .avs_read,
	.avs_write, .avs_waitrequest, .avs_readdata, .sync_sequencer_reset,
	.drv, .gpOe, .pixValid);
